// ### verilog/spc_params.svh
`ifndef SPC_PARAMS_SVH
`define SPC_PARAMS_SVH
`define SPC_REG_OFFSET 2'h0
`define SPC_RESET_VALUE 8'h00
`define SPC_BIT_IRQ_EN 7
`define SPC_BIT_ECLK 6
`define SPC_BIT_EDRV 5
`define SPC_BIT_EEPROM_DATA_BIT 4
`define SPC_BIT_PHYREL 3
`define SPC_BIT_MCLK 2
`define SPC_BIT_MDRV 1
`define SPC_BIT_MGMT_DATA_BIT 0
`define SPC_STS_IRQ_FLAG 7
`endif

// ### verilog/spc_pkg.sv
package spc_pkg;
  typedef enum logic [1:0] {
    spc_own_nvram,
    spc_own_serial
  } spc_owner_t;
  typedef logic [7:0] spc_byte_t;
endpackage

// ### verilog/spc_sync.sv
`timescale 1ns/1ps
// ----------------------------------------
// two-flop level synchroniser
// ----------------------------------------
module spc_sync
(
  input wire logic clk,
  input wire logic din,
  output logic dout
);
  // no reset here: a strap pin must reach dout while reset is still held
  logic stage1;
  logic next_stage1;
  logic next_dout;

  always_comb
  begin
    next_stage1 = din;
    next_dout = stage1;
  end

  always_ff @(posedge clk)
  begin
    stage1 <= next_stage1;
    dout <= next_dout;
  end
endmodule

// ### verilog/spc_serial_pin_control.sv
`timescale 1ns/1ps
`include "spc_params.svh"

// What this block does
// - eeprom pin ownership goes to whichever of the nvram register or this register was written last.
// - any reset hands eeprom pin ownership to the nvram register.
// - adapter soft reset or host bus reset clears every bit of the register.
// - with the irq enable set, a low management data pin sets the irq flag.
// - while this register owns the eeprom pins, the eeprom clock bit drives the eeprom clock pin.
// - with the eeprom port disabled the eeprom clock bit reads 0.
// - the eeprom clock pin is sampled at reset; low means the eeprom port is disabled.
// - eeprom drive enable set drives the data pin from the data bit while this register owns the eeprom pins, else the bit loads from the pin.
// - the phy reset release bit drives the phy reset pin, which is low while the bit is 0.
// - the phy reset release bit changes only by software writes and by any reset, which clears it.
// - the management clock bit drives the management clock pin directly.
// - management drive enable set drives the data pin from the data bit, else the bit loads from the pin.
// - a low management data line, between frames or inside one, is latched in the irq flag.
// - the irq flag clears only on a write of 1 to its bit or on any reset; writing 0 leaves it.
module spc_serial_pin_control
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic adapter_reset,
  input wire logic [1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic sts_wr,
  input wire logic [7:0] sts_wdata,
  input wire logic nvram_wr,
  input wire logic nvram_eeprom_clock,
  input wire logic nvram_eeprom_data,
  input wire logic nvram_eeprom_drive,
  output logic [7:0] reg_rdata,
  output logic mgmt_irq_flag,
  output logic eeprom_disabled,
  output logic serial_owns_eeprom,
  output logic eeprom_clock_pin,
  input wire logic eeprom_clock_pin_in,
  input wire logic eeprom_data_pin_in,
  output logic eeprom_data_pin_out,
  output logic eeprom_data_pin_oe_n,
  output logic mgmt_clock_pin,
  input wire logic mgmt_data_pin_in,
  output logic mgmt_data_pin_out,
  output logic mgmt_data_pin_oe_n,
  output logic phy_reset_pin
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic eclk_sync;
  logic eeprom_data_bit_sync;
  logic mgmt_data_bit_sync;

  // the strap is sensed on the pin level, not on our own clock output
  spc_sync u_eclk_sync (.clk(clk), .din(eeprom_clock_pin_in), .dout(eclk_sync));
  spc_sync u_eeprom_data_bit_sync (.clk(clk), .din(eeprom_data_pin_in), .dout(eeprom_data_bit_sync));
  spc_sync u_mgmt_data_bit_sync (.clk(clk), .din(mgmt_data_pin_in), .dout(mgmt_data_bit_sync));

  // ----------------------------------------
  // register state
  // ----------------------------------------
  spc_pkg::spc_byte_t ctrl;
  spc_pkg::spc_byte_t next_ctrl;
  spc_pkg::spc_owner_t owner;
  spc_pkg::spc_owner_t next_owner;
  logic next_irq;
  logic next_disabled;
  logic strap_pending;
  logic next_strap_pending;
  logic any_reset;
  logic ctrl_write;

  assign any_reset = !reset_n || adapter_reset;
  assign ctrl_write = reg_wr && (reg_addr == `SPC_REG_OFFSET);

  function automatic logic spc_serial_owner(input spc_pkg::spc_owner_t who);
    return who == spc_pkg::spc_own_serial;
  endfunction

  // ----------------------------------------
  // control byte
  // ----------------------------------------
  always_comb
  begin
    next_ctrl = ctrl;
    if (ctrl_write)
    begin
      next_ctrl = reg_wdata;
    end
    // input bits follow the pins while not driven
    if (!next_ctrl[`SPC_BIT_EDRV])
    begin
      next_ctrl[`SPC_BIT_EEPROM_DATA_BIT] = eeprom_data_bit_sync;
    end
    if (!next_ctrl[`SPC_BIT_MDRV])
    begin
      next_ctrl[`SPC_BIT_MGMT_DATA_BIT] = mgmt_data_bit_sync;
    end
    if (any_reset)
    begin
      next_ctrl = `SPC_RESET_VALUE;
    end
  end

  always_ff @(posedge clk)
  begin
    ctrl <= next_ctrl;
  end

  // ----------------------------------------
  // eeprom pin ownership
  // ----------------------------------------
  always_comb
  begin
    next_owner = owner;
    // a same-cycle register write beats the nvram write
    if (ctrl_write)
    begin
      next_owner = spc_pkg::spc_own_serial;
    end
    else if (nvram_wr)
    begin
      next_owner = spc_pkg::spc_own_nvram;
    end
    if (any_reset)
    begin
      next_owner = spc_pkg::spc_own_nvram;
    end
  end

  always_ff @(posedge clk)
  begin
    owner <= next_owner;
  end

  // ----------------------------------------
  // management interrupt flag
  // ----------------------------------------
  always_comb
  begin
    next_irq = mgmt_irq_flag;
    // set wins over a simultaneous write-1 clear
    if (sts_wr && sts_wdata[`SPC_STS_IRQ_FLAG])
    begin
      next_irq = 1'b0;
    end
    // no frame tracking: a low line inside a frame also sets the flag
    if (ctrl[`SPC_BIT_IRQ_EN] && !mgmt_data_bit_sync)
    begin
      next_irq = 1'b1;
    end
    if (any_reset)
    begin
      next_irq = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    mgmt_irq_flag <= next_irq;
  end

  // ----------------------------------------
  // eeprom strap sense
  // ----------------------------------------
  always_comb
  begin
    next_disabled = eeprom_disabled;
    next_strap_pending = 1'b0;
    // tracked all through reset and once more after release
    if (strap_pending || any_reset)
    begin
      next_disabled = !eclk_sync;
    end
    if (any_reset)
    begin
      next_strap_pending = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    eeprom_disabled <= next_disabled;
    strap_pending <= next_strap_pending;
  end

  // ----------------------------------------
  // pin and read-back drivers
  // ----------------------------------------
  spc_pkg::spc_byte_t next_rdata;
  logic next_eclk_pin;
  logic next_eeprom_data_bit_out;
  logic next_eeprom_data_bit_oe_n;

  always_comb
  begin
    next_rdata = next_ctrl;
    if (next_disabled)
    begin
      next_rdata[`SPC_BIT_ECLK] = 1'b0;
    end
    if (spc_serial_owner(next_owner))
    begin
      next_eclk_pin = next_ctrl[`SPC_BIT_ECLK];
      next_eeprom_data_bit_out = next_ctrl[`SPC_BIT_EEPROM_DATA_BIT];
      next_eeprom_data_bit_oe_n = !next_ctrl[`SPC_BIT_EDRV];
    end
    else
    begin
      next_eclk_pin = nvram_eeprom_clock;
      next_eeprom_data_bit_out = nvram_eeprom_data;
      next_eeprom_data_bit_oe_n = !nvram_eeprom_drive;
    end
    // pullup left to sense strap while reset holds the pin released
    if (any_reset)
    begin
      next_eclk_pin = 1'b1;
      next_eeprom_data_bit_oe_n = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    reg_rdata <= next_rdata;
    serial_owns_eeprom <= spc_serial_owner(next_owner);
    eeprom_clock_pin <= next_eclk_pin;
    eeprom_data_pin_out <= next_eeprom_data_bit_out;
    eeprom_data_pin_oe_n <= next_eeprom_data_bit_oe_n;
    mgmt_clock_pin <= next_ctrl[`SPC_BIT_MCLK];
    mgmt_data_pin_out <= next_ctrl[`SPC_BIT_MGMT_DATA_BIT];
    mgmt_data_pin_oe_n <= !next_ctrl[`SPC_BIT_MDRV];
    phy_reset_pin <= next_ctrl[`SPC_BIT_PHYREL];
  end
endmodule

// ### dv/spc_props.sv
`timescale 1ns/1ps
module spc_props
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic adapter_reset,
  input wire logic [1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic sts_wr,
  input wire logic [7:0] sts_wdata,
  input wire logic nvram_wr,
  input wire logic [7:0] reg_rdata,
  input wire logic mgmt_irq_flag,
  input wire logic eeprom_disabled,
  input wire logic serial_owns_eeprom,
  input wire logic eeprom_clock_pin,
  input wire logic mgmt_data_pin_in,
  input wire logic phy_reset_pin
);
  wire w = reg_wr && reg_addr == 2'h0;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n || adapter_reset);
  property p_own; w |=> serial_owns_eeprom; endproperty
  a_own: assert property (p_own) else $error("write kept nvram owner");
  property p_nvr; nvram_wr && !w |=> !serial_owns_eeprom; endproperty
  a_nvr: assert property (p_nvr) else $error("nvram write lost");
  property p_rst; disable iff (1'b0) !reset_n |=> reg_rdata == 8'h00 && !phy_reset_pin
    && !serial_owns_eeprom; endproperty
  a_rst: assert property (p_rst) else $error("reset left state");
  property p_eck; w |=> eeprom_clock_pin == $past(reg_wdata[6]); endproperty
  a_eck: assert property (p_eck) else $error("eeprom clock pin");
  property p_dis; eeprom_disabled |-> !reg_rdata[6]; endproperty
  a_dis: assert property (p_dis) else $error("clock bit read when disabled");
  property p_phy; w |=> phy_reset_pin == $past(reg_wdata[3]); endproperty
  a_phy: assert property (p_phy) else $error("phy reset pin");
  property p_hold; !w |=> $stable(phy_reset_pin); endproperty
  a_hold: assert property (p_hold) else $error("phy reset moved alone");
  property p_irq; (reg_rdata[7] && !mgmt_data_pin_in) [*4] |=> mgmt_irq_flag; endproperty
  a_irq: assert property (p_irq) else $error("irq not raised");
  property p_clr; mgmt_irq_flag && !(sts_wr && sts_wdata[7]) |=> mgmt_irq_flag; endproperty
  a_clr: assert property (p_clr) else $error("irq cleared alone");
endmodule
bind spc_serial_pin_control spc_props u_props (.*);

// ### dv/spc_far_model.sv
`timescale 1ns/1ps
// ----
// eeprom and phy side: both data lines have pull-ups, the phy can only pull low
// ----
module spc_far_model
(
  input wire logic ee_oe_n,
  input wire logic ee_out,
  input wire logic md_oe_n,
  input wire logic md_out,
  input wire logic phy_alert,
  output logic ee_in,
  output logic md_in
);
  assign ee_in = ee_oe_n ? 1'h1 : ee_out;
  assign md_in = ((!md_oe_n && !md_out) || phy_alert) ? 1'h0 : 1'h1;
endmodule

// ### dv/tb_spc_serial_pin_control.sv
`timescale 1ns/1ps
module tb_spc_serial_pin_control;
  logic clk = 0, reset_n = 0, adapter_reset = 0, reg_wr = 0, sts_wr = 0, nvram_wr = 0;
  logic nvram_eeprom_clock = 0, nvram_eeprom_data = 0, nvram_eeprom_drive = 0, phy_alert = 0;
  logic [1:0] reg_addr = 0;
  logic [7:0] reg_wdata = 0, sts_wdata = 0, reg_rdata;
  logic mgmt_irq_flag, eeprom_disabled, serial_owns_eeprom, eeprom_clock_pin;
  logic eeprom_data_pin_in, eeprom_data_pin_out, eeprom_data_pin_oe_n, mgmt_clock_pin;
  logic mgmt_data_pin_in, mgmt_data_pin_out, mgmt_data_pin_oe_n, phy_reset_pin;
  logic eeprom_clock_pin_in = 1;
  int n_mismatch = 0, tests_run = 0;
  spc_serial_pin_control dut (.*);
  spc_far_model far (.ee_oe_n(eeprom_data_pin_oe_n), .ee_out(eeprom_data_pin_out),
    .md_oe_n(mgmt_data_pin_oe_n), .md_out(mgmt_data_pin_out), .phy_alert(phy_alert),
    .ee_in(eeprom_data_pin_in), .md_in(mgmt_data_pin_in));
  initial
  begin
    forever #2.5 clk = ~clk;
  end
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    @(posedge clk);
    #1 reg_wr = 0;
  endtask
  task automatic sts(input logic [7:0] d);
    @(posedge clk);
    #1 sts_wdata = d;
    sts_wr = 1;
    @(posedge clk);
    #1 sts_wr = 0;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    if (n_mismatch == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    idle(10);
    reset_n = 1;
    chk(reg_rdata, 8'h00);
    chk(serial_owns_eeprom, 1'h0);
    idle(3);
    chk(eeprom_disabled, 1'h0);
    wr(2'h0, 8'h08);
    chk(phy_reset_pin, 1'h1);
    chk(serial_owns_eeprom, 1'h1);
    idle(4);
    chk(reg_rdata, 8'h19);
    wr(2'h0, 8'h2A);
    wr(2'h0, 8'h6E);
    chk(eeprom_clock_pin, 1'h1);
    chk(mgmt_clock_pin, 1'h1);
    chk({eeprom_data_pin_oe_n, eeprom_data_pin_out, mgmt_data_pin_oe_n, mgmt_data_pin_out}, 0);
    idle(5);
    chk(mgmt_irq_flag, 1'h0);
    wr(2'h0, 8'h88);
    phy_alert = 1;
    idle(5);
    chk(mgmt_irq_flag, 1'h1);
    chk(reg_rdata, 8'h98);
    phy_alert = 0;
    idle(4);
    sts(8'h7F);
    chk(mgmt_irq_flag, 1'h1);
    sts(8'h80);
    chk(mgmt_irq_flag, 1'h0);
    wr(2'h0, 8'h00);
    chk(phy_reset_pin, 1'h0);
    wr(2'h0, 8'h48);
    idle(20);
    chk(phy_reset_pin, 1'h1);
    @(posedge clk);
    #1 nvram_wr = 1;
    @(posedge clk);
    #1 nvram_wr = 0;
    chk({serial_owns_eeprom, eeprom_clock_pin}, 0);
    wr(2'h1, 8'hFF);
    chk(serial_owns_eeprom, 1'h0);
    eeprom_clock_pin_in = 0;
    adapter_reset = 1;
    idle(3);
    adapter_reset = 0;
    chk(reg_rdata, 8'h00);
    chk(serial_owns_eeprom, 1'h0);
    idle(3);
    chk(eeprom_disabled, 1'h1);
    wr(2'h0, 8'h40);
    chk(reg_rdata, 8'h11);
    chk(eeprom_clock_pin, 1'h1);
    conclude;
  end
  initial
  begin
    #5000;
    n_mismatch++;
    conclude;
  end
endmodule
